//--- rcr_pkg.sv
// Package for the clock register front end: offsets, fields, timing.
// Assumes a 25 MHz register clock and 16-bit word accesses.
package rcr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [15:0] ADDR_CTL = 16'h56c0;
    localparam logic [15:0] ADDR_IEN = 16'h56c2;
    localparam logic [15:0] ADDR_IFLG = 16'h56c4;
    localparam logic [15:0] ADDR_MS = 16'h56c6;
    localparam logic [15:0] ADDR_HOUR = 16'h56c8;
    localparam int BIT_RUN = 0;
    localparam int BIT_HOURFMT = 4;
    localparam int BIT_DECFMT = 5;
    localparam int BIT_STATUS = 8;
    localparam int SRC_COUNT = 10;
    localparam logic [9:0] SRC_RESET = 10'h000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    // Source positions
    localparam int SRC_32HZ = 0;
    localparam int SRC_8HZ = 1;
    localparam int SRC_4HZ = 2;
    localparam int SRC_1HZ = 3;
    localparam int SRC_10S = 4;
    localparam int SRC_1M = 5;
    localparam int SRC_10M = 6;
    localparam int SRC_1H = 7;
    localparam int SRC_HD = 8;
    localparam int SRC_1D = 9;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_HZ = 32;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int TICK_W = 20;
    localparam logic [4:0] SUB_LAST = 5'h1f;
    localparam logic [6:0] BIN_MS_LAST = 7'h3b;
    localparam logic [6:0] BCD_MS_LAST = 7'h59;
    localparam logic [5:0] BIN_H_LAST = 6'h17;
    localparam logic [5:0] BCD_H_LAST = 6'h23;
    localparam logic [5:0] BIN_H12_LAST = 6'h0b;
    localparam logic [5:0] BCD_H12_LAST = 6'h11;
endpackage : rcr_pkg

//--- rcr_time_cnt.sv
// Minute, second, hour and half-of-day counters with boundary pulses.
// Assumes a one-cycle second tick from the parent.
`timescale 1ns/100ps
`default_nettype none
module rcr_time_cnt
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sec_tick_i,
    input wire logic bcd_i,
    input wire logic h12_i,
    input wire logic wr_ms_i,
    input wire logic wr_h_i,
    input wire logic [15:0] wdata_i,
    output logic [6:0] sec_o,
    output logic [6:0] min_o,
    output logic [5:0] hour_o,
    output logic pm_o,
    output logic ten_sec_o,
    output logic min_p_o,
    output logic ten_min_o,
    output logic hour_p_o,
    output logic half_day_o,
    output logic day_o
);
    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic pm;
    } rcr_cnt_t;

    rcr_cnt_t st_r;
    rcr_cnt_t st_nxt;
    logic s_wrap;
    logic m_wrap;
    logic h_wrap;
    logic [6:0] hour_inc;

    // Increment in binary or BCD
    function automatic logic [6:0] rcr_inc(input logic [6:0] v,
                                          input logic bcd);
        if (bcd && v[3:0] == 4'h9)
            rcr_inc = {v[6:4] + 3'h1, 4'h0};
        else
            rcr_inc = v + 7'h01;
    endfunction : rcr_inc

    always_comb
    begin
        st_nxt = st_r;
        hour_inc = rcr_inc({1'b0, st_r.hour}, bcd_i);
        s_wrap = st_r.sec == (bcd_i ? rcr_pkg::BCD_MS_LAST
                                    : rcr_pkg::BIN_MS_LAST);
        m_wrap = st_r.min == (bcd_i ? rcr_pkg::BCD_MS_LAST
                                    : rcr_pkg::BIN_MS_LAST);
        if (h12_i)
            h_wrap = st_r.hour == (bcd_i ? rcr_pkg::BCD_H12_LAST
                                         : rcr_pkg::BIN_H12_LAST);
        else
            h_wrap = st_r.hour == (bcd_i ? rcr_pkg::BCD_H_LAST
                                         : rcr_pkg::BIN_H_LAST);
        ten_sec_o = 1'b0;
        min_p_o = 1'b0;
        ten_min_o = 1'b0;
        hour_p_o = 1'b0;
        half_day_o = 1'b0;
        day_o = 1'b0;
        if (sec_tick_i)
        begin
            ten_sec_o = bcd_i ? (st_r.sec[3:0] == 4'h9)
                              : ((7'(st_r.sec + 7'h01) % 7'd10) == 7'h00);
            if (s_wrap)
            begin
                st_nxt.sec = 7'h00;
                min_p_o = 1'b1;
                ten_min_o = bcd_i ? (st_r.min[3:0] == 4'h9)
                                  : ((7'(st_r.min + 7'h01) % 7'd10) == 7'h00);
                if (m_wrap)
                begin
                    st_nxt.min = 7'h00;
                    hour_p_o = 1'b1;
                    if (h_wrap)
                    begin
                        st_nxt.hour = 6'h00;
                        half_day_o = 1'b1;
                        st_nxt.pm = h12_i ? ~st_r.pm : 1'b0;
                        day_o = h12_i ? st_r.pm : 1'b1;
                    end
                    else
                    begin
                        st_nxt.hour = hour_inc[5:0];
                        if (!h12_i && st_nxt.hour ==
                            (bcd_i ? rcr_pkg::BCD_H12_LAST + 6'h01
                                   : rcr_pkg::BIN_H12_LAST + 6'h01))
                            half_day_o = 1'b1;
                    end
                end
                else
                    st_nxt.min = rcr_inc(st_r.min, bcd_i);
            end
            else
                st_nxt.sec = rcr_inc(st_r.sec, bcd_i);
        end
        if (wr_ms_i)
        begin
            st_nxt.min = wdata_i[14:8];
            st_nxt.sec = wdata_i[6:0];
        end
        if (wr_h_i)
        begin
            st_nxt.pm = wdata_i[7];
            st_nxt.hour = wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sec_o = st_r.sec;
    assign min_o = st_r.min;
    assign hour_o = st_r.hour;
    assign pm_o = st_r.pm;
endmodule : rcr_time_cnt
`default_nettype wire

//--- rcr_regs.sv
// Clock control, interrupt enable and interrupt flag registers.
// Assumes a plain strobe bus with 16-bit words and one-cycle read data.
//
// Contract
// - Control bit 8 reads 1 while counting, 0 when stopped; resets 0.
// - Control bit 0 starts counters when 1, stops when 0; resets 0.
// - Control bit 5 selects BCD counting when 1, binary when 0.
// - Control bit 4 selects 12-hour when 1, 24-hour when 0.
// - Unused bits of control, enable and flag registers read zero.
// - Ten enable bits, day down to 32 Hz, reset 0.
// - Half-day and day enables are independent, each gates own source.
// - Day flag at bit 9 sets on its cause; resets 0.
// - Half-day flag at bit 8 sets on half-day boundary; resets 0.
// - Writing 1 clears a flag; software clears with 1, not 0.
// - Flags bits 7..0: hour, 10 min, minute, 10 s, 1, 4, 8, 32 Hz.
// - Minutes and seconds count 0..59 in 7 bits, binary or BCD.
// - Hours count 0..23 in 24-hour mode, 0..11 in 12-hour mode, in 6 bits, binary or BCD.
`timescale 1ns/100ps
`default_nettype none
module rcr_regs
#(
    // Product divide by default; a bench may shorten it
    parameter int TICK_CYCLES = rcr_pkg::TICK_CYCLES
)
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    output logic IRQ_O
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic run;
        logic running;
        logic bcd;
        logic h12;
        logic [9:0] ien;
        logic [9:0] iflg;
        logic [rcr_pkg::TICK_W-1:0] div;
        logic [4:0] sub;
        logic [15:0] rdata;
        logic irq;
    } rcr_regs_t;

    localparam int TW = rcr_pkg::TICK_W;

    rcr_regs_t st_r;
    rcr_regs_t st_nxt;
    logic tick32;
    logic sec_tick;
    logic wr_ms;
    logic wr_h;
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic pm;
    logic ten_sec;
    logic min_p;
    logic ten_min;
    logic hour_p;
    logic half_day;
    logic day;
    logic [9:0] events;

    // Address match
    function automatic logic rcr_hit(input logic [15:0] a,
                                     input logic [15:0] r);
        rcr_hit = (a == r);
    endfunction : rcr_hit

    assign tick32 = st_r.running &&
        (st_r.div == TW'(TICK_CYCLES - 1));
    assign sec_tick = tick32 && (st_r.sub == rcr_pkg::SUB_LAST);
    assign wr_ms = WR_I && rcr_hit(ADDR_I, rcr_pkg::ADDR_MS);
    assign wr_h = WR_I && rcr_hit(ADDR_I, rcr_pkg::ADDR_HOUR);

    // ****************************************
    // Time counters
    // ****************************************
    rcr_time_cnt u_cnt
    (
        .clk_i(CLK_SYS_I),
        .rst_i(RESET_I),
        .sec_tick_i(sec_tick),
        .bcd_i(st_r.bcd),
        .h12_i(st_r.h12),
        .wr_ms_i(wr_ms),
        .wr_h_i(wr_h),
        .wdata_i(WDATA_I),
        .sec_o(sec),
        .min_o(min),
        .hour_o(hour),
        .pm_o(pm),
        .ten_sec_o(ten_sec),
        .min_p_o(min_p),
        .ten_min_o(ten_min),
        .hour_p_o(hour_p),
        .half_day_o(half_day),
        .day_o(day)
    );

    // ****************************************
    // Events
    // ****************************************
    always_comb
    begin
        events = rcr_pkg::SRC_RESET;
        events[rcr_pkg::SRC_32HZ] = tick32;
        events[rcr_pkg::SRC_8HZ] = tick32 && (st_r.sub[1:0] == 2'h3);
        events[rcr_pkg::SRC_4HZ] = tick32 && (st_r.sub[2:0] == 3'h7);
        events[rcr_pkg::SRC_1HZ] = sec_tick;
        events[rcr_pkg::SRC_10S] = ten_sec;
        events[rcr_pkg::SRC_1M] = min_p;
        events[rcr_pkg::SRC_10M] = ten_min;
        events[rcr_pkg::SRC_1H] = hour_p;
        events[rcr_pkg::SRC_HD] = half_day;
        events[rcr_pkg::SRC_1D] = day;
    end

    // ****************************************
    // Register logic
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.running = st_r.run;
        if (st_r.running)
        begin
            if (tick32)
            begin
                st_nxt.div = '0;
                st_nxt.sub = st_r.sub + 5'h01;
            end
            else
                st_nxt.div = st_r.div + TW'(1);
        end
        if (WR_I && rcr_hit(ADDR_I, rcr_pkg::ADDR_CTL))
        begin
            st_nxt.run = WDATA_I[rcr_pkg::BIT_RUN];
            st_nxt.bcd = WDATA_I[rcr_pkg::BIT_DECFMT];
            st_nxt.h12 = WDATA_I[rcr_pkg::BIT_HOURFMT];
        end
        if (WR_I && rcr_hit(ADDR_I, rcr_pkg::ADDR_IEN))
            st_nxt.ien = WDATA_I[9:0];
        if (WR_I && rcr_hit(ADDR_I, rcr_pkg::ADDR_IFLG))
            st_nxt.iflg = st_r.iflg & ~WDATA_I[9:0];
        // Set wins over a same-cycle clear
        st_nxt.iflg = st_nxt.iflg | events;
        st_nxt.irq = |(st_nxt.iflg & st_nxt.ien);
        st_nxt.rdata = rcr_pkg::WORD_ZERO;
        if (RD_I)
        begin
            case (ADDR_I)
                rcr_pkg::ADDR_CTL:
                begin
                    st_nxt.rdata[rcr_pkg::BIT_STATUS] = st_r.running;
                    st_nxt.rdata[rcr_pkg::BIT_DECFMT] = st_r.bcd;
                    st_nxt.rdata[rcr_pkg::BIT_HOURFMT] = st_r.h12;
                    st_nxt.rdata[rcr_pkg::BIT_RUN] = st_r.run;
                end
                rcr_pkg::ADDR_IEN: st_nxt.rdata[9:0] = st_r.ien;
                rcr_pkg::ADDR_IFLG: st_nxt.rdata[9:0] = st_r.iflg;
                rcr_pkg::ADDR_MS: st_nxt.rdata = {1'b0, min, 1'b0, sec};
                rcr_pkg::ADDR_HOUR: st_nxt.rdata = {8'h00, pm, 1'b0, hour};
                default: st_nxt.rdata = rcr_pkg::WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign RDATA_O = st_r.rdata;
    assign IRQ_O = st_r.irq;
endmodule : rcr_regs
`default_nettype wire

//--- rcr_regs_props.sv
// Checker of the clock register front end, bound to its ports.
// Assumes the strobe bus with read data in the cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module rcr_regs_props
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RESET_I);
    logic wc, wi, wm, wh, rc, ri, rf, rm, rh, unm;
    assign wc = WR_I && ADDR_I == rcr_pkg::ADDR_CTL;
    assign wi = WR_I && ADDR_I == rcr_pkg::ADDR_IEN;
    assign wm = WR_I && ADDR_I == rcr_pkg::ADDR_MS;
    assign wh = WR_I && ADDR_I == rcr_pkg::ADDR_HOUR;
    assign rc = RD_I && ADDR_I == rcr_pkg::ADDR_CTL;
    assign ri = RD_I && ADDR_I == rcr_pkg::ADDR_IEN;
    assign rf = RD_I && ADDR_I == rcr_pkg::ADDR_IFLG;
    assign rm = RD_I && ADDR_I == rcr_pkg::ADDR_MS;
    assign rh = RD_I && ADDR_I == rcr_pkg::ADDR_HOUR;
    assign unm = RD_I && !(ADDR_I inside {rcr_pkg::ADDR_CTL,
        rcr_pkg::ADDR_IEN, rcr_pkg::ADDR_IFLG, rcr_pkg::ADDR_MS,
        rcr_pkg::ADDR_HOUR});
    // ****************************************
    // Properties
    // ****************************************
    property p_ctl_rsv;
        rc |=> (RDATA_O & 16'hfece) == 16'h0000;
    endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("ctl spare bits");
    property p_en_rsv;
        ri |=> RDATA_O[15:10] == 6'h00;
    endproperty
    a_en_rsv: assert property (p_en_rsv) else $error("ien spare bits");
    property p_flg_rsv;
        rf |=> RDATA_O[15:10] == 6'h00;
    endproperty
    a_flg_rsv: assert property (p_flg_rsv) else $error("iflg spare");
    property p_status;
        wc ##1 !wc ##1 rc |=> RDATA_O[8] == $past(WDATA_I[0], 3);
    endproperty
    a_status: assert property (p_status) else $error("status wrong");
    property p_ctl_rw;
        wc ##1 rc |=> RDATA_O[5:4] == $past(WDATA_I[5:4], 2)
            && RDATA_O[0] == $past(WDATA_I[0], 2);
    endproperty
    a_ctl_rw: assert property (p_ctl_rw) else $error("ctl field");
    property p_en_rw;
        wi ##1 ri |=> RDATA_O[9:0] == $past(WDATA_I[9:0], 2);
    endproperty
    a_en_rw: assert property (p_en_rw) else $error("ien readback");
    property p_irq_off;
        wi && WDATA_I[9:0] == 10'h000 |=> !IRQ_O;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not off");
    property p_ms_rw;
        wm ##1 rm |=> RDATA_O == ($past(WDATA_I, 2) & 16'h7f7f);
    endproperty
    a_ms_rw: assert property (p_ms_rw) else $error("ms readback");
    property p_hour_rw;
        wh ##1 rh |=> RDATA_O == ($past(WDATA_I, 2) & 16'h00bf);
    endproperty
    a_hour_rw: assert property (p_hour_rw) else $error("hour");
    property p_unmap;
        unm |=> RDATA_O == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule : rcr_regs_props
bind rcr_regs rcr_regs_props u_rcr_regs_props(.CLK_SYS_I(CLK_SYS_I),
    .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O));
`default_nettype wire

//--- rcr_regs_tb_top.sv
// Self-checking bench of the clock register front end.
// Assumes one 25 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rcr_regs_tb_top;
    logic CLK_SYS_I = 1'b0;
    logic RESET_I = 1'b1;
    logic [15:0] ADDR_I = 16'h0000;
    logic [15:0] WDATA_I = 16'h0000;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic [15:0] RDATA_O;
    logic IRQ_O;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    // Short divide so that boundaries come within the run
    localparam int TB_TICK = 4;
    rcr_regs #(.TICK_CYCLES(TB_TICK)) u_rcr_regs(.CLK_SYS_I(CLK_SYS_I),
        .RESET_I(RESET_I),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .IRQ_O(IRQ_O));
    // ****************************************
    // Clock, timeout, verdict
    // ****************************************
    initial
    begin
        forever #20 CLK_SYS_I = ~CLK_SYS_I;
    end
    always @(posedge CLK_SYS_I)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            test_done();
        end
    end
    task automatic test_done();
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // ****************************************
    // Bus cycles and compare
    // ****************************************
    task automatic chk16(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16
    task automatic cyc(input logic w, input logic r, input logic [15:0] a,
        input logic [15:0] d);
        @(posedge CLK_SYS_I);
        WR_I <= w;
        RD_I <= r;
        ADDR_I <= a;
        WDATA_I <= d;
    endtask : cyc
    task automatic idle();
        cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
    endtask : idle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp,
        input string what);
        cyc(1'b0, 1'b1, a, 16'h0000);
        idle();
        #1 chk16(what, exp, RDATA_O);
    endtask : rd
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_zero();
        rd(rcr_pkg::ADDR_CTL, 16'h0000, "ctl reset");
        rd(rcr_pkg::ADDR_IEN, 16'h0000, "ien reset");
        rd(rcr_pkg::ADDR_IFLG, 16'h0000, "iflg reset");
        chk16("irq reset", 16'h0000, {15'h0000, IRQ_O});
    endtask : t_zero
    task automatic t_ctl();
        wr(rcr_pkg::ADDR_CTL, 16'h0030);
        rd(rcr_pkg::ADDR_CTL, 16'h0030, "ctl modes");
        wr(rcr_pkg::ADDR_CTL, 16'hffff);
        idle();
        rd(rcr_pkg::ADDR_CTL, 16'h0131, "ctl run");
        wr(rcr_pkg::ADDR_CTL, 16'h0021);
        rd(rcr_pkg::ADDR_CTL, 16'h0121, "ctl bcd");
        wr(rcr_pkg::ADDR_CTL, 16'h0010);
        idle();
        rd(rcr_pkg::ADDR_CTL, 16'h0010, "ctl stop");
    endtask : t_ctl
    task automatic t_ien();
        for (int i = 0; i < rcr_pkg::SRC_COUNT; i++)
        begin
            wr(rcr_pkg::ADDR_IEN, 16'h0001 << i);
            rd(rcr_pkg::ADDR_IEN, 16'h0001 << i, "ien bit");
        end
        wr(rcr_pkg::ADDR_IEN, 16'hffff);
        rd(rcr_pkg::ADDR_IEN, 16'h03ff, "ien all");
    endtask : t_ien
    task automatic t_flag();
        wr(rcr_pkg::ADDR_IFLG, 16'hffff);
        rd(rcr_pkg::ADDR_IFLG, 16'h0000, "iflg w1c");
        chk16("irq enabled", 16'h0000, {15'h0000, IRQ_O});
        wr(rcr_pkg::ADDR_IEN, 16'h0000);
        idle();
        idle();
        chk16("irq masked", 16'h0000, {15'h0000, IRQ_O});
    endtask : t_flag
    task automatic t_time();
        wr(rcr_pkg::ADDR_MS, 16'h5959);
        rd(rcr_pkg::ADDR_MS, 16'h5959, "ms bcd top");
        wr(rcr_pkg::ADDR_MS, 16'hffff);
        rd(rcr_pkg::ADDR_MS, 16'h7f7f, "ms fields");
        wr(rcr_pkg::ADDR_HOUR, 16'h00a3);
        rd(rcr_pkg::ADDR_HOUR, 16'h00a3, "hour pm");
        wr(rcr_pkg::ADDR_HOUR, 16'hffff);
        rd(rcr_pkg::ADDR_HOUR, 16'h00bf, "hour fields");
    endtask : t_time
    task automatic t_unmap();
        wr(16'h56ca, 16'hffff);
        rd(16'h56ca, 16'h0000, "unmapped");
        rd(16'h56c1, 16'h0000, "odd address");
    endtask : t_unmap
    task automatic t_wrap(input logic [15:0] mode, input logic [15:0] ms,
        input logic [15:0] hr);
        wr(rcr_pkg::ADDR_CTL, mode);
        wr(rcr_pkg::ADDR_IEN, 16'h0000);
        wr(rcr_pkg::ADDR_MS, ms);
        wr(rcr_pkg::ADDR_HOUR, hr);
        wr(rcr_pkg::ADDR_IFLG, 16'h03ff);
        rd(rcr_pkg::ADDR_IFLG, 16'h0000, "iflg before run");
        wr(rcr_pkg::ADDR_CTL, mode | 16'h0001);
        repeat (140) idle();
        wr(rcr_pkg::ADDR_CTL, mode);
        idle();
        rd(rcr_pkg::ADDR_IFLG, 16'h03ff, "iflg wrap");
        rd(rcr_pkg::ADDR_HOUR, 16'h0000, "hour wrap");
        chk16("irq none enabled", 16'h0000, {15'h0000, IRQ_O});
        wr(rcr_pkg::ADDR_IFLG, 16'h0000);
        rd(rcr_pkg::ADDR_IFLG, 16'h03ff, "iflg write 0");
        wr(rcr_pkg::ADDR_IEN, 16'h0100);
        idle();
        #1 chk16("irq half day", 16'h0001, {15'h0000, IRQ_O});
        wr(rcr_pkg::ADDR_IFLG, 16'h0100);
        idle();
        #1 chk16("irq hd cleared", 16'h0000, {15'h0000, IRQ_O});
        rd(rcr_pkg::ADDR_IFLG, 16'h02ff, "iflg one cleared");
        wr(rcr_pkg::ADDR_IEN, 16'h0200);
        idle();
        #1 chk16("irq day", 16'h0001, {15'h0000, IRQ_O});
        wr(rcr_pkg::ADDR_IFLG, 16'h03ff);
        rd(rcr_pkg::ADDR_IFLG, 16'h0000, "iflg all cleared");
    endtask : t_wrap
    task automatic t_rst();
        wr(rcr_pkg::ADDR_CTL, 16'h0031);
        wr(rcr_pkg::ADDR_IEN, 16'h0155);
        idle();
        @(posedge CLK_SYS_I);
        RESET_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        RESET_I <= 1'b0;
        t_zero();
    endtask : t_rst
    initial
    begin
        repeat (8) @(posedge CLK_SYS_I);
        RESET_I <= 1'b0;
        t_zero();
        t_ctl();
        t_ien();
        t_flag();
        t_time();
        t_unmap();
        t_wrap(16'h0000, 16'h3b3b, 16'h0017);
        t_wrap(16'h0030, 16'h5959, 16'h0091);
        t_rst();
        idle();
        test_done();
    end
endmodule : rcr_regs_tb_top
`default_nettype wire
